// *** logic/aidr_cfg.svh ***
`ifndef AIDR_CFG_SVH
`define AIDR_CFG_SVH
// ******************************
// record byte offsets
// ******************************
`define AIDR_OFS_SUMMARY      5'h00
`define AIDR_OFS_CLASS        5'h01
`define AIDR_OFS_SPARE        5'h02
`define AIDR_OFS_INTERNAL     5'h03
`define AIDR_OFS_KIND         5'h04
`define AIDR_OFS_DIAG_BITS    5'h05
`define AIDR_OFS_CH_COUNT     5'h06
`define AIDR_OFS_GROUP        5'h07
`define AIDR_OFS_CH0          5'h08
`define AIDR_OFS_UNUSED0      5'h0C
`define AIDR_OFS_STAMP0       5'h10
`define AIDR_RECORD_BYTES     5'h14
// ******************************
// field positions
// ******************************
`define AIDR_SUM_FAIL         0
`define AIDR_SUM_INTERNAL     1
`define AIDR_SUM_EXTERNAL     2
`define AIDR_SUM_CHANNEL      3
`define AIDR_SUM_AUX          4
`define AIDR_SUM_PARAM        7
`define AIDR_INT_BUFOVF       3
`define AIDR_INT_COMM         4
`define AIDR_CH_PARAM         0
`define AIDR_CH_WIREBRK       4
`define AIDR_CH_UNDER         6
`define AIDR_CH_OVER          7
// ******************************
// constant values
// ******************************
`define AIDR_CLASS_ANALOG     4'h5
`define AIDR_CLASS_CHINFO     4
`define AIDR_KIND_VALUE       7'h71
`define AIDR_DIAG_BITS_VALUE  8'h08
`define AIDR_CH_COUNT_VALUE   8'h04
`define AIDR_CH_DEFINED_MASK  8'hD1
`define AIDR_RESET_BYTE       8'h00
// ******************************
// timing
// ******************************
`define AIDR_CLK_PERIOD_NS    5
`define AIDR_TICK_PERIOD_NS   1000
`define AIDR_TICK_CYCLES      (`AIDR_TICK_PERIOD_NS / `AIDR_CLK_PERIOD_NS)
`endif

// *** logic/aidr_pkg.sv ***
package aidr_pkg;
   // channel type codes of the kind byte
   typedef enum logic [6:0] {
      AIDR_KIND_DIG_IN  = 7'h70,
      AIDR_KIND_ANA_IN  = 7'h71,
      AIDR_KIND_DIG_OUT = 7'h72,
      AIDR_KIND_ANA_OUT = 7'h73,
      AIDR_KIND_ANA_IO  = 7'h74,
      AIDR_KIND_COUNTER = 7'h76
   } aidr_kind_t;
   typedef logic [7:0] aidr_byte_t;
endpackage

// *** logic/aidr_record.sv ***
`timescale 1ns/1ps
`include "aidr_cfg.svh"
// Functional notes
// [RULE1] summary bits: failure, internal, external, aux supply
// [RULE2] summary bit 7 parameter, bit 3 channel
// [RULE3] class byte 0101b plus channel-info bit
// [RULE4] internal byte: buffer overflow, communication error
// [RULE5] channel kind byte reads analog input
// [RULE6] diagnostic bits per channel reads 08h
// [RULE7] channel count reads 04h
// [RULE8] group byte bit n per channel n
// [RULE9] channel byte bit 0 parameter error
// [RULE10] channel byte bit 4 wire break
// [RULE11] channel bits 6/7 underflow/overflow
// [RULE12] bytes of channels 4 to 7 reserved
// [RULE13] ticker captured into timestamp at event
// [RULE14] microsecond ticker starts at zero
// [RULE15] ticker wraps after 2^32-1
// [RULE16] going event raised when cause clears; the code raises it only when the last standing cause clears
// [RULE17] fault indicator lit while any error
// [RULE18] channel error lights channel indicator
// [RULE19] reserved bits and bytes read zero
// [RULE20] group bit ORs channel; summary ORs groups
module aidr_record #(
   parameter int TICK_DIV = `AIDR_TICK_CYCLES
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // module level fault sources
   input  wire logic        moduleFailure,
   input  wire logic        internalError,
   input  wire logic        externalError,
   input  wire logic        auxSupplyMissing,
   input  wire logic        paramError,
   input  wire logic        diagBufOverflow,
   input  wire logic        internalCommError,
   // per channel fault sources
   input  wire logic [3:0]  chParamError,
   input  wire logic [3:0]  chWireBreak,
   input  wire logic [3:0]  chUnderflow,
   input  wire logic [3:0]  chOverflow,
   // record read port
   input  wire logic        rdEn,
   input  wire logic [4:0]  rdAddr,
   output logic      [7:0]  rdData,
   output logic             rdValid,
   // events and indicators
   output logic             diagIncoming,
   output logic             diagGoing,
   output logic             module_fault_indicator,
   output logic      [3:0]  channelIndicator,
   output logic      [31:0] usTicker,
   output logic      [31:0] event_timestamp_us
);

   // ******************************
   // elaboration checks
   // ******************************
   if (TICK_DIV < 1 || TICK_DIV > 256) begin : g_bad_div
      $error("TICK_DIV must lie in 1..256");
   end

   localparam logic [7:0] DIV_LAST = 8'(TICK_DIV - 1);

   // ******************************
   // fault state
   // ******************************
   aidr_pkg::aidr_byte_t chFaultNext [4];
   aidr_pkg::aidr_byte_t chFaultReg  [4];
   aidr_pkg::aidr_byte_t summaryNext;
   aidr_pkg::aidr_byte_t summaryReg;
   aidr_pkg::aidr_byte_t internalNext;
   aidr_pkg::aidr_byte_t internalReg;
   aidr_pkg::aidr_byte_t groupNext;
   aidr_pkg::aidr_byte_t groupReg;
   logic [47:0]          faultNext;
   logic [47:0]          faultReg;
   logic                 anyErrNext;
   logic                 anyErrReg;
   logic                 incomingNext;
   logic                 goingNext;

   always_comb begin
      groupNext = `AIDR_RESET_BYTE;
      for (int i = 0; i < 4; i++) begin
         chFaultNext[i] = `AIDR_RESET_BYTE;
         // [RULE9] parameter error bit
         chFaultNext[i][`AIDR_CH_PARAM] = chParamError[i];
         // [RULE10] wire break bit
         chFaultNext[i][`AIDR_CH_WIREBRK] = chWireBreak[i];
         // [RULE11] range under/overflow
         chFaultNext[i][`AIDR_CH_UNDER] = chUnderflow[i];
         chFaultNext[i][`AIDR_CH_OVER] = chOverflow[i];
         // [RULE8] group bit per channel
         // [RULE20] group ORs defined bits
         groupNext[i] = |(chFaultNext[i] & `AIDR_CH_DEFINED_MASK);
      end
   end

   always_comb begin
      summaryNext = `AIDR_RESET_BYTE;
      // [RULE1] module level causes
      summaryNext[`AIDR_SUM_FAIL] = moduleFailure;
      summaryNext[`AIDR_SUM_INTERNAL] = internalError;
      summaryNext[`AIDR_SUM_EXTERNAL] = externalError;
      summaryNext[`AIDR_SUM_AUX] = auxSupplyMissing;
      // [RULE2] parameter and channel bits
      // [RULE20] channel bit ORs groups
      summaryNext[`AIDR_SUM_PARAM] = paramError;
      summaryNext[`AIDR_SUM_CHANNEL] = |groupNext;
   end

   always_comb begin
      internalNext = `AIDR_RESET_BYTE;
      // [RULE4] internal fault flags
      internalNext[`AIDR_INT_BUFOVF] = diagBufOverflow;
      internalNext[`AIDR_INT_COMM] = internalCommError;
   end

   assign faultNext = {summaryNext, internalNext, chFaultNext[3], chFaultNext[2],
                       chFaultNext[1], chFaultNext[0]};
   assign anyErrNext = |faultNext;
   // a new cause while others stand is still an incoming event
   assign incomingNext = |(faultNext & ~faultReg);
   // [RULE16] going raised by hardware itself
   assign goingNext = anyErrReg & ~anyErrNext;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int i = 0; i < 4; i++) begin
            chFaultReg[i] <= `AIDR_RESET_BYTE;
         end
         summaryReg <= `AIDR_RESET_BYTE;
         internalReg <= `AIDR_RESET_BYTE;
         groupReg <= `AIDR_RESET_BYTE;
         faultReg <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            chFaultReg[i] <= chFaultNext[i];
         end
         summaryReg <= summaryNext;
         internalReg <= internalNext;
         groupReg <= groupNext;
         faultReg <= faultNext;
      end
   end

   // ******************************
   // events and indicators
   // ******************************
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         anyErrReg <= 1'b0;
         diagIncoming <= 1'b0;
         diagGoing <= 1'b0;
         channelIndicator <= 4'h0;
      end else begin
         // [RULE17] lit first incoming to last going
         anyErrReg <= anyErrNext;
         diagIncoming <= incomingNext;
         diagGoing <= goingNext;
         // [RULE18] channel indicator follows error
         channelIndicator <= groupNext[3:0];
      end
   end

   assign module_fault_indicator = anyErrReg;

   // ******************************
   // microsecond ticker
   // ******************************
   logic [7:0]  divReg;
   logic [31:0] tickReg;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         divReg <= 8'h00;
      end else if (divReg == DIV_LAST) begin
         divReg <= 8'h00;
      end else begin
         divReg <= divReg + 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      // [RULE14] zero from srst
      if (srst) begin
         tickReg <= 32'h0000_0000;
      end else if (divReg == DIV_LAST) begin
         // [RULE15] natural 32-bit wrap
         tickReg <= tickReg + 32'h0000_0001;
      end
   end

   assign usTicker = tickReg;

   // ******************************
   // timestamp capture
   // ******************************
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         event_timestamp_us <= 32'h0000_0000;
      end else if (incomingNext || goingNext) begin
         // [RULE13] ticker taken at event
         event_timestamp_us <= tickReg;
      end
   end

   // ******************************
   // record read port
   // ******************************
   aidr_pkg::aidr_byte_t readByte;
   logic [1:0]           byteSel;

   assign byteSel = rdAddr[1:0];

   always_comb begin
      readByte = `AIDR_RESET_BYTE;
      unique case (rdAddr[4:2])
         3'h0: begin
            unique case (byteSel)
               2'h0: readByte = summaryReg;
               // [RULE3] analog class, channel info
               2'h1: readByte = {3'h0, 1'b1, `AIDR_CLASS_ANALOG};
               // [RULE19] spare byte reads zero
               2'h2: readByte = `AIDR_RESET_BYTE;
               2'h3: readByte = internalReg;
            endcase
         end
         3'h1: begin
            unique case (byteSel)
               // [RULE5] analog input kind
               2'h0: readByte = {1'b0, aidr_pkg::AIDR_KIND_ANA_IN};
               // [RULE6] bits per channel
               2'h1: readByte = `AIDR_DIAG_BITS_VALUE;
               // [RULE7] channel count
               2'h2: readByte = `AIDR_CH_COUNT_VALUE;
               2'h3: readByte = groupReg;
            endcase
         end
         3'h2: readByte = chFaultReg[byteSel];
         // [RULE12] channels 4 to 7 zero
         3'h3: readByte = `AIDR_RESET_BYTE;
         3'h4: readByte = event_timestamp_us[{byteSel, 3'h0} +: 8];
         // [RULE19] beyond the record reads zero
         default: readByte = `AIDR_RESET_BYTE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdData <= `AIDR_RESET_BYTE;
         rdValid <= 1'b0;
      end else begin
         rdValid <= rdEn;
         // data holds between reads so a slow reader sees it stable
         if (rdEn) begin
            rdData <= readByte;
         end
      end
   end

   // ******************************
   // checks
   // ******************************
   AST_SUMMARY_BITS: assert property ( // [RULE1]
      @(posedge sys_clk) disable iff (srst)
      ##1 summaryReg[2:0] == {$past(externalError), $past(internalError), $past(moduleFailure)}
          && summaryReg[4] == $past(auxSupplyMissing))
      else $error("summary module bits wrong");

   AST_SUMMARY_CHAN: assert property ( // [RULE2]
      @(posedge sys_clk) disable iff (srst)
      summaryReg[3] == (|groupReg[3:0]) && summaryReg[6:5] == 2'h0)
      else $error("summary channel bit wrong");

   AST_CLASS_READ: assert property ( // [RULE3]
      @(posedge sys_clk) disable iff (srst)
      rdEn && rdAddr == `AIDR_OFS_CLASS |=> rdValid && rdData == 8'h15)
      else $error("class byte wrong");

   AST_INTERNAL_BITS: assert property ( // [RULE4]
      @(posedge sys_clk) disable iff (srst)
      ##1 internalReg[4] == $past(internalCommError)
          && internalReg[3] == $past(diagBufOverflow))
      else $error("internal byte wrong");

   AST_CONST_READ: assert property ( // [RULE6]
      @(posedge sys_clk) disable iff (srst)
      rdEn && rdAddr == `AIDR_OFS_DIAG_BITS |=> rdValid && rdData == 8'h08)
      else $error("bits per channel byte wrong");

   AST_COUNT_READ: assert property ( // [RULE7]
      @(posedge sys_clk) disable iff (srst)
      rdEn && rdAddr == `AIDR_OFS_CH_COUNT |=> rdValid && rdData == 8'h04)
      else $error("channel count byte wrong");

   AST_UNUSED_ZERO: assert property ( // [RULE12]
      @(posedge sys_clk) disable iff (srst)
      rdEn && rdAddr[4:2] == 3'h3 |=> rdData == 8'h00)
      else $error("unused channel byte not zero");

   AST_GROUP_OR: assert property ( // [RULE20]
      @(posedge sys_clk) disable iff (srst)
      groupReg[0] == |(chFaultReg[0] & 8'hD1) && groupReg[7:4] == 4'h0)
      else $error("group bit not OR of channel");

   AST_STAMP_TAKE: assert property ( // [RULE13]
      @(posedge sys_clk) disable iff (srst)
      diagIncoming || diagGoing |-> event_timestamp_us == $past(usTicker))
      else $error("timestamp not captured");

   AST_TICK_STEP: assert property ( // [RULE15]
      @(posedge sys_clk) disable iff (srst)
      divReg == DIV_LAST |=> usTicker == $past(usTicker) + 32'h0000_0001)
      else $error("ticker did not advance");

   AST_TICK_HOLD: assert property ( // [RULE14]
      @(posedge sys_clk) disable iff (srst)
      divReg != DIV_LAST |=> $stable(usTicker))
      else $error("ticker moved early");

   AST_GOING_EVENT: assert property ( // [RULE16]
      @(posedge sys_clk) disable iff (srst)
      $fell(module_fault_indicator) |-> diagGoing)
      else $error("going event missing");

   AST_FAULT_LAMP: assert property ( // [RULE17]
      @(posedge sys_clk) disable iff (srst)
      diagIncoming |-> module_fault_indicator)
      else $error("fault indicator dark on event");

   AST_CHAN_LAMP: assert property ( // [RULE18]
      @(posedge sys_clk) disable iff (srst)
      chWireBreak[1] |=> channelIndicator[1])
      else $error("channel indicator dark");

   AST_KIND_READ: assert property ( // [RULE5]
      @(posedge sys_clk) disable iff (srst)
      rdEn && rdAddr == `AIDR_OFS_KIND |=> rdValid && rdData == 8'h71)
      else $error("channel kind byte wrong");

   AST_CHAN_BITS: assert property ( // [RULE9]
      @(posedge sys_clk) disable iff (srst)
      ##1 chFaultReg[1] == {$past(chOverflow[1]), $past(chUnderflow[1]), 1'b0,
                            $past(chWireBreak[1]), 3'h0, $past(chParamError[1])})
      else $error("channel byte bits wrong");

endmodule

// *** verification/aidr_head_model.sv ***
`timescale 1ns/1ps
// ***********************************
// head module reading record bytes
// ***********************************
module aidr_head_model (
   // clock
   input  wire logic       sys_clk,
   // record read port
   output logic            rdEn,
   output logic      [4:0] rdAddr,
   input  wire logic [7:0] rdData,
   input  wire logic       rdValid
);
   initial begin
      rdEn   = 1'b0;
      rdAddr = 5'h00;
   end

   // one strobe per byte; the address is scrambled once the strobe drops
   // so a design that samples it late reads the wrong byte
   task automatic readByte(input logic [4:0] a, output logic [7:0] d, output logic v);
      @(posedge sys_clk);
      rdEn   <= 1'b1;
      rdAddr <= a;
      @(posedge sys_clk);
      rdEn   <= 1'b0;
      rdAddr <= ~a;
      #1;
      v = rdValid;
      d = rdData;
   endtask
endmodule

// *** verification/aidr_record_tb.sv ***
`timescale 1ns/1ps
// ***********************************
// bench for the diagnostic record
// ***********************************
module aidr_record_tb;
   localparam int TICK = 2;
   logic        sys_clk = 1'b0;
   logic        srst    = 1'b1;
   logic [6:0]  modCause = 7'h00;
   logic [3:0]  chPar = 4'h0, chWire = 4'h0, chUnder = 4'h0, chOver = 4'h0;
   logic        rdEn, rdValid, diagIncoming, diagGoing, faultLed;
   logic [4:0]  rdAddr;
   logic [7:0]  rdData;
   logic [3:0]  chLed;
   logic [31:0] usTicker, stamp, t;
   int          fail_count = 0, n_tests = 0, cycles = 0;

   aidr_record #(.TICK_DIV(TICK)) dut (
      .sys_clk(sys_clk), .srst(srst),
      .moduleFailure(modCause[0]), .internalError(modCause[1]),
      .externalError(modCause[2]), .auxSupplyMissing(modCause[3]),
      .paramError(modCause[4]), .diagBufOverflow(modCause[5]),
      .internalCommError(modCause[6]),
      .chParamError(chPar), .chWireBreak(chWire),
      .chUnderflow(chUnder), .chOverflow(chOver),
      .rdEn(rdEn), .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid),
      .diagIncoming(diagIncoming), .diagGoing(diagGoing),
      .module_fault_indicator(faultLed), .channelIndicator(chLed),
      .usTicker(usTicker), .event_timestamp_us(stamp));

   aidr_head_model head (
      .sys_clk(sys_clk), .rdEn(rdEn), .rdAddr(rdAddr),
      .rdData(rdData), .rdValid(rdValid));

   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   // hang guard: the whole sequence needs well under two thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         give_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      head.readByte(a, d, v);
      check({v, d}, {1'b1, exp});
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [7:0] resetByte(input int a);
      case (a)
         1: return 8'h15;
         4: return 8'h71;
         5: return 8'h08;
         6: return 8'h04;
         default: return 8'h00;
      endcase
   endfunction

   // cause applied or removed at a clock edge, ticker caught mid-cycle
   task automatic stepCause(input logic [6:0] c);
      @(posedge sys_clk);
      modCause <= c;
      @(negedge sys_clk);
      t = usTicker;
      @(posedge sys_clk);
      #1;
   endtask

   initial begin
      logic [7:0] m;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      #1;
      check(usTicker, 32'h0000_0000);
      t = usTicker;
      repeat (20) @(posedge sys_clk);
      #1;
      check(usTicker - t, 20 / TICK);
      for (int a = 0; a < 32; a++) rd(a[4:0], resetByte(a));
      rd(5'h01, 8'h15);
      rd(5'h04, 8'h71);
      rd(5'h05, 8'h08);
      rd(5'h06, 8'h04);
      rd(5'h0C, 8'h00);
      $display("test record map done");

      // module level causes, one at a time
      for (int i = 0; i < 7; i++) begin
         @(posedge sys_clk);
         modCause <= 7'h01 << i;
         m = (i == 4) ? 8'h80 : (i == 3) ? 8'h10 : (i < 3) ? 8'h01 << i : 8'h00;
         rd(5'h00, m);
         rd(5'h03, (i == 5) ? 8'h08 : (i == 6) ? 8'h10 : 8'h00);
         check(faultLed, 1'b1);
         @(posedge sys_clk);
         modCause <= 7'h00;
      end
      rd(5'h00, 8'h00);
      $display("test module causes done");

      // every channel with every cause kind
      for (int ch = 0; ch < 4; ch++) begin
         for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            chPar   <= (k == 0) ? 4'h1 << ch : 4'h0;
            chWire  <= (k == 1) ? 4'h1 << ch : 4'h0;
            chUnder <= (k == 2) ? 4'h1 << ch : 4'h0;
            chOver  <= (k == 3) ? 4'h1 << ch : 4'h0;
            m = (k == 0) ? 8'h01 : (k == 1) ? 8'h10 : (k == 2) ? 8'h40 : 8'h80;
            rd(5'h08 + 5'(ch), m);
            rd(5'h07, 8'h01 << ch);
            rd(5'h00, 8'h08);
            check(chLed, 4'h1 << ch);
         end
      end
      @(posedge sys_clk);
      {chPar, chWire, chUnder, chOver} <= 16'h0000;
      rd(5'h07, 8'h00);
      $display("test channel causes done");

      // event pulses and timestamp
      stepCause(7'h01);
      check(diagIncoming, 1'b1);
      check(stamp, t);
      @(posedge sys_clk);
      #1;
      check(diagIncoming, 1'b0);
      rd(5'h10, t[7:0]);
      rd(5'h11, t[15:8]);
      rd(5'h12, t[23:16]);
      rd(5'h13, t[31:24]);
      stepCause(7'h00);
      check(diagGoing, 1'b1);
      check(faultLed, 1'b0);
      check(stamp, t);
      $display("test events done");
      give_verdict();
   end
endmodule
